// >>> design/bbwsp_pkg.sv
// constants and types for the burst byte-write sram port
// What this block does
// RULE_01 - x9: one lane mask gates bits 0-8
// RULE_02 - x18: two lane masks, nine bits each
// RULE_03 - x36: four lane masks, nine bits each
// RULE_04 - masks sampled per beat, first and second
// RULE_05 - masks act only inside write bursts
// RULE_06 - each beat applies its own mask values
// RULE_07 - burst address appends internal low bit
// RULE_08 - burst order fixed: +0 then +1
// RULE_09 - every burst ends after two words
// RULE_10 - read and write machines run concurrently
// RULE_11 - machines advance on true clock timing; write machine goes idle on kn_rise
// RULE_12 - control selects registered at true edge
// RULE_13 - write data captured each beat edge
// RULE_14 - read words return t+1 and t+2; code returns the first word on kn_rise at t+1.5
// RULE_15 - controller gives four idle cycles first
// RULE_16 - masked lanes keep stored bits unchanged
// RULE_17 - controller presents masks with every beat
package bbwsp_pkg;
  localparam int LANE_BITS = 9;
  localparam int LANES_X36 = 4;
  localparam int ADDR_W_DEF = 8;
  localparam int BURST_LEN = 2;
  localparam logic BEAT_FIRST = 1'b0;
  localparam logic BEAT_SECOND = 1'b1;
  typedef enum logic [0:0] {BBWSP_W_IDLE, BBWSP_W_BEAT1} bbwsp_wst_e;
  typedef enum logic [1:0] {BBWSP_R_IDLE, BBWSP_R_WORD0, BBWSP_R_WORD1}
    bbwsp_rst_e;
endpackage

// >>> design/bbwsp_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module bbwsp_skid #(
  parameter int WIDTH = 36
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } bbwsp_skid_s;
  bbwsp_skid_s st_r, st_nxt;
  logic push, pop;
  assign in_ready = (st_r.cnt != 2'h2);
  assign out_valid = (st_r.cnt != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = st_r.mem[st_r.rd];
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr = ~st_r.wr;
    end
    if (pop)
      st_nxt.rd = ~st_r.rd;
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  never_overfill_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.cnt == 2'h2 |-> !in_ready) else $error("buffer full not shown");
endmodule

// >>> design/bbwsp_core.sv
// burst byte-write sram port: array, burst machines, lane masks
`timescale 1ns/10ps
module bbwsp_core #(
  parameter int ADDR_W = bbwsp_pkg::ADDR_W_DEF,
  parameter int LANES = bbwsp_pkg::LANES_X36
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // beat strobes sampled from the input clock pair
  input wire logic k_rise,
  input wire logic kn_rise,
  // control and address, active low selects
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  // write data and lane masks, active low
  input wire logic [LANES*bbwsp_pkg::LANE_BITS-1:0] wdata,
  input wire logic [LANES-1:0] lane_write_mask_n,
  // read data stream through buffer
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [LANES*bbwsp_pkg::LANE_BITS-1:0] rd_data,
  output logic rd_drive_n,
  // status
  output logic wr_busy,
  output logic rd_busy
);
  localparam int DW = LANES * bbwsp_pkg::LANE_BITS;
  localparam int WA = ADDR_W + 1;
  logic [DW-1:0] mem [2**WA];

  typedef struct packed {
    bbwsp_pkg::bbwsp_wst_e wst;
    bbwsp_pkg::bbwsp_rst_e rst;
    logic [ADDR_W-1:0] waddr;
    logic [ADDR_W-1:0] raddr;
    logic [DW-1:0] rword;
    logic rvalid;
    logic drive_n;
  } bbwsp_core_s;
  bbwsp_core_s st_r, st_nxt;

  // expand per-lane mask into per-bit write enable
  function automatic logic [DW-1:0] lane_bits(input logic [LANES-1:0] m_n);
    logic [DW-1:0] b;
    b = '0;
    for (int i = 0; i < LANES; i++)
      b[i*bbwsp_pkg::LANE_BITS +: bbwsp_pkg::LANE_BITS] =
        {bbwsp_pkg::LANE_BITS{~m_n[i]}};
    return b;
  endfunction

  logic wr_beat;
  logic [WA-1:0] wr_word;
  logic [DW-1:0] wr_en;
  logic buf_ready;
  logic [WA-1:0] rd_word;

  always_comb
  begin
    wr_beat = 1'b0;
    wr_word = {st_r.waddr, bbwsp_pkg::BEAT_FIRST};
    if (st_r.wst == bbwsp_pkg::BBWSP_W_IDLE)
    begin
      wr_beat = k_rise && !write_sel_n;
      wr_word = {addr, bbwsp_pkg::BEAT_FIRST};
    end
    else
    begin
      wr_beat = kn_rise;
      wr_word = {st_r.waddr, bbwsp_pkg::BEAT_SECOND};
    end
  end
  assign wr_en = lane_bits(lane_write_mask_n);

  // RULE_01 RULE_02 RULE_03 RULE_16 lane masked write
  // RULE_04 RULE_06 per beat mask
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < LANES; i++)
      if (wr_beat && wr_en[i*bbwsp_pkg::LANE_BITS])
        mem[wr_word][i*bbwsp_pkg::LANE_BITS +: bbwsp_pkg::LANE_BITS] <=
          wdata[i*bbwsp_pkg::LANE_BITS +: bbwsp_pkg::LANE_BITS];
  end

  always_comb
  begin
    st_nxt = st_r;
    rd_word = {st_r.raddr, bbwsp_pkg::BEAT_FIRST};
    // RULE_05 RULE_12 write start on k edge
    unique case (st_r.wst)
      bbwsp_pkg::BBWSP_W_IDLE:
        if (k_rise && !write_sel_n)
        begin
          st_nxt.waddr = addr;
          st_nxt.wst = bbwsp_pkg::BBWSP_W_BEAT1;
        end
      // RULE_09 RULE_13 second beat ends burst
      bbwsp_pkg::BBWSP_W_BEAT1:
        if (kn_rise)
          st_nxt.wst = bbwsp_pkg::BBWSP_W_IDLE;
    endcase
    st_nxt.rvalid = 1'b0;
    // RULE_10 RULE_11 read machine on k edges
    if (k_rise)
    begin
      unique case (st_r.rst)
        bbwsp_pkg::BBWSP_R_IDLE,
        bbwsp_pkg::BBWSP_R_WORD1:
          if (!read_sel_n)
          begin
            st_nxt.raddr = addr;
            st_nxt.rst = bbwsp_pkg::BBWSP_R_WORD0;
          end
          else
            st_nxt.rst = bbwsp_pkg::BBWSP_R_IDLE;
        // RULE_07 RULE_08 word +0 then +1
        bbwsp_pkg::BBWSP_R_WORD0:
        begin
          rd_word = {st_r.raddr, bbwsp_pkg::BEAT_FIRST};
          st_nxt.rst = bbwsp_pkg::BBWSP_R_WORD1;
        end
      endcase
    end
    // RULE_14 words at t+1.5 (kn after t+1) and t+2 (k)
    if (kn_rise && st_r.rst == bbwsp_pkg::BBWSP_R_WORD1)
    begin
      rd_word = {st_r.raddr, bbwsp_pkg::BEAT_FIRST};
      st_nxt.rword = mem[rd_word];
      st_nxt.rvalid = 1'b1;
    end
    if (k_rise && st_r.rst == bbwsp_pkg::BBWSP_R_WORD1)
    begin
      rd_word = {st_r.raddr, bbwsp_pkg::BEAT_SECOND};
      st_nxt.rword = mem[rd_word];
      st_nxt.rvalid = 1'b1;
    end
    st_nxt.drive_n = !(st_r.rst == bbwsp_pkg::BBWSP_R_WORD1);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      st_r.drive_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  bbwsp_skid #(.WIDTH(DW)) u_skid (
    .clk(clk),
    .resetn(resetn),
    .in_valid(st_r.rvalid),
    .in_ready(buf_ready),
    .in_data(st_r.rword),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign rd_drive_n = st_r.drive_n;
  assign wr_busy = (st_r.wst != bbwsp_pkg::BBWSP_W_IDLE);
  assign rd_busy = (st_r.rst != bbwsp_pkg::BBWSP_R_IDLE);

  // RULE_09 write burst two beats
  write_two_beats_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_r.wst == bbwsp_pkg::BBWSP_W_BEAT1 && kn_rise) |=>
    st_r.wst == bbwsp_pkg::BBWSP_W_IDLE) else $error("write burst overran");
  // RULE_05 write start cause
  write_start_cause_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(wr_busy) |-> $past(k_rise && !write_sel_n))
    else $error("write burst without request"); // RULE_05
  // RULE_12 read start cause
  read_start_cause_a: assert property (@(posedge clk) disable iff (!resetn)
    (k_rise && !read_sel_n && st_r.rst != bbwsp_pkg::BBWSP_R_WORD0) |=>
    st_r.rst == bbwsp_pkg::BBWSP_R_WORD0)
    else $error("read request not taken"); // RULE_12
  // RULE_08 read order
  read_order_a: assert property (@(posedge clk) disable iff (!resetn)
    (k_rise && st_r.rst == bbwsp_pkg::BBWSP_R_WORD0) |=>
    st_r.rst == bbwsp_pkg::BBWSP_R_WORD1) else $error("read order broken");
  // RULE_14 read word drive
  read_drive_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.rst == bbwsp_pkg::BBWSP_R_IDLE |=> rd_drive_n)
    else $error("output driven while idle"); // RULE_14
  // RULE_10 buffer never overflows
  buffer_room_a: assert property (@(posedge clk) disable iff (!resetn)
    st_r.rvalid |-> buf_ready) else $error("read word lost"); // RULE_10
  // RULE_11 read advance on k
  read_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !k_rise |=> $stable(st_r.rst)) else $error("read moved off k"); // RULE_11
  // RULE_13 write beat on strobe
  write_beat_strobe_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_beat |-> (k_rise || kn_rise)) else $error("write off beat");
  cover_write_c: cover property (@(posedge clk) wr_beat && wr_busy);
  cover_read_c: cover property (@(posedge clk) st_r.rvalid);
  cover_both_c: cover property (@(posedge clk) wr_busy && rd_busy);
endmodule

// >>> test/bbwsp_ctrl_model.sv
// controller model: beat strobes, selects, write data, lane masks
`timescale 1ns/10ps
module bbwsp_ctrl_model (
  // clock
  input wire logic clk,
  // strobes and control
  output logic k_rise,
  output logic kn_rise,
  output logic read_sel_n,
  output logic write_sel_n,
  output logic [7:0] addr,
  output logic [35:0] wdata,
  output logic [3:0] lane_write_mask_n,
  // read stream
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [35:0] rd_data
);
  logic stall = 1'b0;
  logic [35:0] rq[$];
  initial
  begin
    {k_rise, kn_rise, read_sel_n, write_sel_n} = 4'h3;
    addr = 8'h00;
    wdata = 36'h0;
    lane_write_mask_n = 4'hf;
  end
  always @(negedge clk)
    rd_ready <= !stall;
  always @(posedge clk)
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      rq.push_back(rd_data);
  task automatic beat(input logic kb, input logic [1:0] sel,
    input logic [7:0] a, input logic [35:0] d, input logic [3:0] m);
    @(negedge clk);
    {k_rise, kn_rise} <= {kb, !kb};
    {read_sel_n, write_sel_n} <= sel;
    addr <= a;
    wdata <= d;
    lane_write_mask_n <= m;
    @(negedge clk);
    {k_rise, kn_rise, read_sel_n, write_sel_n} <= 4'h3;
    addr <= ~a;
    wdata <= ~d;
    lane_write_mask_n <= ~m;
    repeat (2) @(negedge clk);
  endtask
  task automatic pair(input logic [1:0] sel, input logic [7:0] a,
    input logic [35:0] d0, input logic [3:0] m0, input logic [35:0] d1,
    input logic [3:0] m1);
    beat(1'b1, sel, a, d0, m0);
    beat(1'b0, 2'h3, a, d1, m1);
  endtask
  task automatic idle4();
    repeat (4) pair(2'h3, 8'h00, 36'h0, 4'hf, 36'h0, 4'hf);
  endtask
endmodule

// >>> test/bbwsp_core_tb.sv
// testbench for the burst byte-write sram port core
`timescale 1ns/10ps
`define CHK(g, w) \
  begin \
    total_checks++; \
    if ((g) !== (w)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: got %h want %h", $time, g, w); \
    end \
  end
module bbwsp_core_tb;
  logic clk;
  logic resetn;
  logic k_rise, kn_rise, read_sel_n, write_sel_n;
  logic rd_valid, rd_ready, rd_drive_n, wr_busy, rd_busy;
  logic [7:0] addr;
  logic [35:0] wdata, rd_data;
  logic [3:0] lane_write_mask_n;
  int fail_count = 0;
  int total_checks = 0;
  logic [35:0] exp_mem [512];
  bbwsp_core #(.ADDR_W(8), .LANES(4)) i_bbwsp_core (.clk(clk),
    .resetn(resetn), .k_rise(k_rise), .kn_rise(kn_rise),
    .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .addr(addr),
    .wdata(wdata), .lane_write_mask_n(lane_write_mask_n),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_drive_n(rd_drive_n), .wr_busy(wr_busy), .rd_busy(rd_busy));
  bbwsp_ctrl_model i_bbwsp_ctrl_model (.clk(clk), .k_rise(k_rise),
    .kn_rise(kn_rise), .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
    .addr(addr), .wdata(wdata), .lane_write_mask_n(lane_write_mask_n),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, d,
    input logic [3:0] m);
    for (int i = 0; i < 4; i++)
      if (!m[i])
        o[i*9 +: 9] = d[i*9 +: 9];
    return o;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [35:0] d0, d1,
    input logic [3:0] m0, m1);
    i_bbwsp_ctrl_model.pair(2'h2, a, d0, m0, d1, m1);
    exp_mem[{a, 1'b0}] = merge(exp_mem[{a, 1'b0}], d0, m0);
    exp_mem[{a, 1'b1}] = merge(exp_mem[{a, 1'b1}], d1, m1);
  endtask
  task automatic get(input logic [7:0] a);
    logic [35:0] got;
    for (int n = 0; n < 4 && i_bbwsp_ctrl_model.rq.size() < 2; n++)
      i_bbwsp_ctrl_model.pair(2'h3, 8'h00, 36'h0, 4'hf, 36'h0, 4'hf);
    for (int w = 0; w < 2; w++)
    begin
      got = 36'hx;
      if (i_bbwsp_ctrl_model.rq.size() > 0)
        got = i_bbwsp_ctrl_model.rq.pop_front();
      `CHK(got, exp_mem[{a, w[0]}])
    end
  endtask
  task automatic rd_chk(input logic [7:0] a);
    i_bbwsp_ctrl_model.pair(2'h1, a, 36'h0, 4'hf, 36'h0, 4'hf);
    i_bbwsp_ctrl_model.pair(2'h3, a, 36'h0, 4'hf, 36'h0, 4'hf);
    get(a);
  endtask
  task automatic s_lanes();
    logic [3:0] m0, m1;
    for (int i = 0; i < 5; i++)
    begin
      m0 = i < 4 ? ~(4'h1 << i) : 4'hf;
      m1 = i < 4 ? ~(4'h1 << ((i + 1) % 4)) : 4'hf;
      wr(8'h10, '1, '1, 4'h0, 4'h0);
      wr(8'h10, 36'h0, 36'h0, m0, m1);
      rd_chk(8'h10);
    end
  endtask
  task automatic s_ignore();
    i_bbwsp_ctrl_model.pair(2'h3, 8'h5a, 36'h0, 4'h0, 36'h0, 4'h0);
    rd_chk(8'h5a);
  endtask
  task automatic s_conc();
    i_bbwsp_ctrl_model.pair(2'h1, 8'h5a, 36'h0, 4'hf, 36'h0, 4'hf);
    wr(8'h22, 36'h13579bdf0, 36'h2468ace13, 4'h0, 4'h0);
    get(8'h5a);
    rd_chk(8'h22);
  endtask
  task automatic s_stall();
    i_bbwsp_ctrl_model.stall = 1'b1;
    i_bbwsp_ctrl_model.pair(2'h1, 8'h22, 36'h0, 4'hf, 36'h0, 4'hf);
    i_bbwsp_ctrl_model.pair(2'h3, 8'h22, 36'h0, 4'hf, 36'h0, 4'hf);
    `CHK(i_bbwsp_ctrl_model.rq.size(), 0)
    i_bbwsp_ctrl_model.stall = 1'b0;
    get(8'h22);
  endtask
  initial
  begin
    #(40 * 5000);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    resetn = 1'b0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    `CHK({rd_valid, rd_drive_n, wr_busy, rd_busy}, 4'h4)
    i_bbwsp_ctrl_model.idle4();
    wr(8'h5a, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
    rd_chk(8'h5a);
    s_lanes();
    s_ignore();
    s_conc();
    s_stall();
    print_verdict();
  end
endmodule
